//--- rtl/sw_port_pkg.sv
// shared constants and carrier types for the switch-side port data interface
package sw_port_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_MHZ      = 250;
    localparam int REF_CLK_MHZ      = 50;
    localparam int REF_DIV          = SYS_CLK_MHZ / REF_CLK_MHZ;
    localparam int REF_HIGH_CYC     = 2;
    localparam int REF_LOSS_NS      = 100;
    localparam int REF_LOSS_CYC     = (REF_LOSS_NS * SYS_CLK_MHZ) / 1000;
    localparam int SLOW_HOLD_TICKS  = 10;
    localparam int SNI_BIT_TICKS    = 5;
    localparam int SNI_CLK_HIGH     = 2;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] COUNT_OFFSET  = 8'h08;

    localparam int CTRL_SPEED100_BIT  = 0;
    localparam int CTRL_SERIAL_BIT    = 1;
    localparam int CTRL_HALF_DUP_BIT  = 2;
    localparam int CTRL_REF_OFF_BIT   = 3;
    localparam int CTRL_WIDTH         = 4;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    localparam int STAT_CLOCK_MODE_BIT = 0;
    localparam int STAT_REF_OK_BIT     = 1;
    localparam int STAT_RUNNING_BIT    = 2;
    localparam int STAT_COLLISION_BIT  = 3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [1:0] data;
    } symbol_s;
endpackage : sw_port_pkg

//--- rtl/sw_port_iface.sv
// switch-side reduced / serial port data interface with apb control
//
// Functional notes
// - reduced interface carries traffic at 10 or 100 Mbps
// - one 50 MHz reference times both directions, internal or external
// - clock mode drives the reference out on the receive-clock pin, the bit clock in serial mode
// - separate two-bit transmit and receive data paths
// - strap defaults to clock mode; device then sources the reference
// - strap low selects normal mode; reference taken on transmit-clock pin
// - normal mode: transmit-clock reference clocks chip, crystal ignored
// - phy-side reference input never becomes the whole-chip clock
// - normal mode: register can switch off the receive-clock output
// - status bit reports clock mode or normal mode
// - normal mode starts only once the external reference is present
// - mac-to-mac: device drives valid and data, takes enable and data
// - mac-to-phy: same pins, roles swapped by board wiring
// - no strap or register chooses mac or phy role
// - serial mode moves one bit per clock on bit 0
// - serial signals split into transmit and receive groups
// - half-duplex serial: collision output asserted on collision
// - transmit data qualified by enable; receive data flagged valid
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
module sw_port_iface
    import sw_port_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CLOCK_MODE_STRAP,
    output logic             CORE_CLK_FROM_TX_PIN,
    input  wire logic        SW_TX_CLOCK_PIN,
    input  wire logic        SW_TX_ENABLE_PIN,
    input  wire logic [1:0]  SW_TX_DATA_PINS,
    output logic             SW_RX_CLOCK_PIN,
    output logic             SW_RX_CLOCK_OE,
    output logic             SW_CARRIER_VALID_PIN,
    output logic [1:0]       SW_RX_DATA_PINS,
    output logic             SW_COLLISION_PIN,
    output symbol_s          TX_SYMBOL,
    input  wire symbol_s     RX_SYMBOL,
    output logic             RX_READY
);
    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    logic       clock_mode_reg;
    logic       strap_done_reg;
    logic [2:0] strap_sync;
    logic [1:0] strap_wait_reg;

    // strap latched once its three-stage synchroniser has filled
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            clock_mode_reg <= 1'b1;
            strap_done_reg <= 1'b0;
            strap_sync     <= 3'h7;
            strap_wait_reg <= 2'h0;
        end else begin
            strap_sync <= {strap_sync[1:0], CLOCK_MODE_STRAP};
            if (strap_wait_reg != 2'h3) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end else if (!strap_done_reg && strap_sync[1] == strap_sync[2]) begin
                clock_mode_reg <= strap_sync[2];
                strap_done_reg <= 1'b1;
            end
        end
    end

    // phy-side reference is deliberately never a candidate source
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CORE_CLK_FROM_TX_PIN <= 1'b0;
        end else begin
            CORE_CLK_FROM_TX_PIN <= strap_done_reg & ~clock_mode_reg;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // bit 3 ref clock, bit 2 enable, bits 1:0 data
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_filt;
    logic [3:0] agree;

    assign agree = ~(pin_s2 ^ pin_s3);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1   <= 4'h0;
            pin_s2   <= 4'h0;
            pin_s3   <= 4'h0;
            pin_filt <= 4'h0;
        end else begin
            pin_s1   <= {SW_TX_CLOCK_PIN, SW_TX_ENABLE_PIN, SW_TX_DATA_PINS};
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_filt <= (pin_filt & ~agree) | (pin_s3 & agree);
        end
    end

    logic ref_in_d;
    logic ext_edge;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ref_in_d <= 1'b0;
        end else begin
            ref_in_d <= pin_filt[3];
        end
    end

    assign ext_edge = pin_filt[3] & ~ref_in_d;

    // ----------------------------------------------------------------
    // reference generation and presence
    // ----------------------------------------------------------------
    logic [2:0] div_reg;
    logic       int_tick;
    logic       ref_tick;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_reg <= 3'h0;
        end else if (div_reg == 3'(REF_DIV - 1)) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    assign int_tick = (div_reg == 3'h0);
    // normal mode times everything from the transmit-clock pin
    assign ref_tick = clock_mode_reg ? int_tick : ext_edge;

    logic [4:0] loss_reg;
    logic       ref_ok_reg;
    logic       running;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            loss_reg   <= 5'h0;
            ref_ok_reg <= 1'b0;
        end else if (ext_edge) begin
            loss_reg   <= 5'h0;
            ref_ok_reg <= 1'b1;
        end else if (loss_reg == 5'(REF_LOSS_CYC)) begin
            ref_ok_reg <= 1'b0;
        end else begin
            loss_reg <= loss_reg + 5'h1;
        end
    end

    assign running = strap_done_reg & (clock_mode_reg | ref_ok_reg);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic                  speed100;
    logic                  serial_mode;
    logic                  half_duplex;
    logic                  ref_off;
    logic                  apb_setup;
    logic                  apb_write;
    logic                  addr_ok;

    assign speed100    = ctrl_reg[CTRL_SPEED100_BIT];
    assign serial_mode = ctrl_reg[CTRL_SERIAL_BIT];
    assign half_duplex = ctrl_reg[CTRL_HALF_DUP_BIT];
    assign ref_off     = ctrl_reg[CTRL_REF_OFF_BIT];
    assign apb_setup   = PSEL & ~PENABLE;
    assign apb_write   = PSEL & PENABLE & PWRITE & addr_ok;
    assign addr_ok     = (PADDR == CTRL_OFFSET) | (PADDR == STATUS_OFFSET)
                       | (PADDR == COUNT_OFFSET);

    // speed and mode selection by software
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RESET;
        end else if (apb_write && PADDR == CTRL_OFFSET) begin
            ctrl_reg <= PWDATA[CTRL_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // symbol timing
    // ----------------------------------------------------------------
    logic [3:0] sym_cnt_reg;
    logic [3:0] sym_last;
    logic       sym_stb;

    // ten reference clocks per symbol at 10 Mbps
    // one serial bit per bit clock
    always_comb begin
        if (serial_mode) begin
            sym_last = 4'(SNI_BIT_TICKS - 1);
        end else if (speed100) begin
            sym_last = 4'h0;
        end else begin
            sym_last = 4'(SLOW_HOLD_TICKS - 1);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sym_cnt_reg <= 4'h0;
        end else if (!running) begin
            sym_cnt_reg <= 4'h0;
        end else if (ref_tick) begin
            sym_cnt_reg <= (sym_cnt_reg >= sym_last) ? 4'h0 : sym_cnt_reg + 4'h1;
        end
    end

    assign sym_stb  = running & ref_tick & (sym_cnt_reg == 4'h0);
    assign RX_READY = sym_stb;

    // ----------------------------------------------------------------
    // receive-clock pin
    // ----------------------------------------------------------------
    // serial mode drives the bit clock; clock mode otherwise drives reference out; normal mode may disable it
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SW_RX_CLOCK_PIN <= 1'b0;
            SW_RX_CLOCK_OE  <= 1'b0;
        end else begin
            SW_RX_CLOCK_OE <= strap_done_reg & (clock_mode_reg | ~ref_off);
            if (serial_mode) begin
                SW_RX_CLOCK_PIN <= running & (sym_cnt_reg < 4'(SNI_CLK_HIGH));
            end else if (clock_mode_reg) begin
                SW_RX_CLOCK_PIN <= (div_reg < 3'(REF_HIGH_CYC));
            end else begin
                SW_RX_CLOCK_PIN <= pin_filt[3];
            end
        end
    end

    // ----------------------------------------------------------------
    // data paths
    // ----------------------------------------------------------------
    // fixed pin roles; board wiring sets mac or phy role
    // inbound symbol taken on strobe, qualified by enable
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            TX_SYMBOL <= '0;
        end else begin
            TX_SYMBOL.valid <= sym_stb & pin_filt[2];
            if (sym_stb) begin
                TX_SYMBOL.data <= serial_mode ? {1'b0, pin_filt[0]} : pin_filt[1:0];
            end
        end
    end

    // serial data uses bit 0 only
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SW_CARRIER_VALID_PIN <= 1'b0;
            SW_RX_DATA_PINS      <= 2'h0;
        end else if (!running) begin
            SW_CARRIER_VALID_PIN <= 1'b0;
            SW_RX_DATA_PINS      <= 2'h0;
        end else if (sym_stb) begin
            SW_CARRIER_VALID_PIN <= RX_SYMBOL.valid;
            SW_RX_DATA_PINS      <= RX_SYMBOL.valid ?
                                    {RX_SYMBOL.data[1] & ~serial_mode, RX_SYMBOL.data[0]} :
                                    2'h0;
        end else if (serial_mode) begin
            // a switch into serial mode must not leave a stale bit 1 from a two-bit symbol
            SW_RX_DATA_PINS[1]   <= 1'b0;
        end
    end

    // collision while transmitting in half-duplex serial mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SW_COLLISION_PIN <= 1'b0;
        end else begin
            SW_COLLISION_PIN <= serial_mode & half_duplex
                              & SW_CARRIER_VALID_PIN & pin_filt[2];
        end
    end

    logic [15:0] sym_count_reg;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sym_count_reg <= 16'h0;
        end else if (sym_stb && pin_filt[2]) begin
            sym_count_reg <= sym_count_reg + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // apb read side
    // ----------------------------------------------------------------
    // zero wait states: read data is prepared in the setup cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0;
        end else if (apb_setup) begin
            case (PADDR)
                CTRL_OFFSET:   PRDATA <= {28'h0, ctrl_reg};
                STATUS_OFFSET: PRDATA <= {28'h0, SW_COLLISION_PIN, running,
                                          ref_ok_reg, clock_mode_reg};
                COUNT_OFFSET:  PRDATA <= {16'h0, sym_count_reg};
                default:       PRDATA <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_ref_divider: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (clock_mode_reg && int_tick) |=> !int_tick [*4] ##1 int_tick)
        else $error("internal reference period wrong");

    a_ref_out_enable: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (strap_done_reg && !clock_mode_reg && ref_off) |=> !SW_RX_CLOCK_OE)
        else $error("reference output not disabled");

    a_clock_mode_out: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (strap_done_reg && clock_mode_reg) |=> SW_RX_CLOCK_OE)
        else $error("reference output missing in clock mode");

    a_wait_for_ref: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (!clock_mode_reg && !ref_ok_reg) |=> !TX_SYMBOL.valid)
        else $error("traffic before reference present");

    a_slow_hold: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (sym_stb && clock_mode_reg && !speed100 && !serial_mode)
            |=> !sym_stb [*8])
        else $error("slow symbol not held");

    a_collision_out: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (serial_mode && half_duplex && SW_CARRIER_VALID_PIN && pin_filt[2])
            |=> SW_COLLISION_PIN)
        else $error("collision not flagged");

    a_status_mode: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (apb_setup && PADDR == STATUS_OFFSET)
            |=> PRDATA[STAT_CLOCK_MODE_BIT] == clock_mode_reg)
        else $error("status mode bit wrong");

    a_core_source: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        strap_done_reg |=> CORE_CLK_FROM_TX_PIN == !clock_mode_reg)
        else $error("core clock source wrong");

    a_serial_bit0: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        serial_mode && $stable(serial_mode) |-> !SW_RX_DATA_PINS[1])
        else $error("serial data off bit 0");

    a_rx_capture: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (sym_stb && pin_filt[2]) |=> TX_SYMBOL.valid)
        else $error("qualified symbol lost");

endmodule : sw_port_iface

//--- verif/ext_mac_model.sv
// external mac model standing on the far side of the switch-side port
`timescale 1ns/100ps
module ext_mac_model (
    input  wire logic       use_own_ref,
    input  wire logic       ref_run,
    input  wire logic       dev_ref,
    output logic            own_ref,
    output logic            tx_en,
    output logic [1:0]      tx_data
);
    logic ref_clk;

    initial begin
        own_ref = 1'b0;
        tx_en   = 1'b0;
        tx_data = 2'h0;
    end

    // own reference, only used once the strap latched normal mode
    always #24 own_ref = ref_run ? ~own_ref : 1'b0;

    // in clock mode the device's receive-clock output, reference or serial bit clock, times this side too
    assign ref_clk = use_own_ref ? own_ref : dev_ref;

    // data launched on the falling edge, with enable
    task send_sym(input logic [1:0] d, input int hold);
        @(negedge ref_clk);
        tx_en   = 1'b1;
        tx_data = d;
        repeat (hold - 1) @(negedge ref_clk);
    endtask : send_sym

    // idle lines show the inverse of the last value, never a stale copy
    task end_frame();
        @(negedge ref_clk);
        tx_en   = 1'b0;
        tx_data = ~tx_data;
    endtask : end_frame
endmodule : ext_mac_model

//--- verif/test_sw_port_iface.sv
// self-checking bench for the switch-side port data interface
`timescale 1ns/100ps
module test_sw_port_iface
    import sw_port_pkg::*;
;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, strap, core_clk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        tx_clk, tx_en, rx_clk, rx_oe, crs_dv, coll, rx_ready, own_ref, err;
    logic [1:0]  tx_data, rx_data;
    symbol_s     tx_symbol, rx_symbol, exp_n;
    logic        ref_run, tx_busy, ser_mode, chk_out, rdy_n;
    logic [2:0]  out_cnt;
    logic [1:0]  got_q[$], exp_q[$];
    int          errors, checks_done, rx_edges, n0;

    sw_port_iface dut_u (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CLOCK_MODE_STRAP(strap), .CORE_CLK_FROM_TX_PIN(core_clk),
        .SW_TX_CLOCK_PIN(tx_clk), .SW_TX_ENABLE_PIN(tx_en), .SW_TX_DATA_PINS(tx_data),
        .SW_RX_CLOCK_PIN(rx_clk), .SW_RX_CLOCK_OE(rx_oe), .SW_CARRIER_VALID_PIN(crs_dv),
        .SW_RX_DATA_PINS(rx_data), .SW_COLLISION_PIN(coll), .TX_SYMBOL(tx_symbol),
        .RX_SYMBOL(rx_symbol), .RX_READY(rx_ready));
    ext_mac_model mac_u (.use_own_ref(~strap), .ref_run(ref_run), .dev_ref(rx_clk),
        .own_ref(own_ref), .tx_en(tx_en), .tx_data(tx_data));

    // board loopback: in clock mode the receive-clock pin feeds the transmit-clock pin
    assign tx_clk = strap ? rx_clk : own_ref;

    always #2 clk = ~clk;
    always @(posedge rx_clk) rx_edges++;

    // ----------------------------------------------------------------
    // link monitors and outbound source
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (tx_symbol.valid === 1'b1)
            got_q.push_back(ser_mode ? {1'b0, tx_symbol.data[0]} : tx_symbol.data);
        if (chk_out && rdy_n && exp_n.valid)
            check(32'({crs_dv, rx_data}), 32'({1'b1, ser_mode ? {1'b0, exp_n.data[0]}
                : exp_n.data}), "outbound symbol");
        else if (chk_out && rdy_n)
            check(32'(crs_dv), 32'h0, "outbound idle");
        rdy_n = rx_ready;
        exp_n = rx_symbol;
    end

    always @(posedge clk) begin
        if (rdy_n === 1'b1) begin
            out_cnt   <= out_cnt + 3'h1;
            rx_symbol <= symbol_s'({tx_busy | out_cnt[2], out_cnt[1:0]});
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb(1'b0, a, 32'h0, rd, err);
        check(rd & mask, exp, "register read");
    endtask : reg_chk

    task set_ctrl(input logic [31:0] v);
        chk_out = 1'b0;
        apb(1'b1, CTRL_OFFSET, v, rd, err);
        ser_mode = v[CTRL_SERIAL_BIT];
        repeat (60) @(posedge clk);
        chk_out = 1'b1;
    endtask : set_ctrl

    task do_reset(input logic s);
        chk_out = 1'b0;
        ser_mode = 1'b0;
        ref_run = 1'b0;
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : do_reset

    task frame(input int n, input int hold, input logic ser);
        logic [1:0] d;
        got_q.delete();
        exp_q.delete();
        for (int i = 0; i < n; i++) begin
            d = 2'((i * 3) + 1);
            if (ser) d = {~d[0], d[0]};
            exp_q.push_back(ser ? {1'b0, d[0]} : d);
            mac_u.send_sym(d, hold);
        end
        mac_u.end_frame();
        repeat (40) @(posedge clk);
        check(32'(got_q.size()), 32'(n), "inbound count");
        for (int i = 0; i < n; i++)
            check(32'(i < got_q.size() ? got_q[i] : 2'bxx), 32'(exp_q[i]), "inbound");
    endtask : frame

    task tally_and_finish();
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {clk, rst_n, psel, penable, pwrite, paddr, pwdata, strap} = '0;
        {rx_symbol, out_cnt, tx_busy, rdy_n, exp_n} = '0;
        {errors, checks_done, rx_edges} = '0;
        do_reset(1'b1);
        check(32'(core_clk), 32'h0, "core clock source");
        check(32'(rx_oe), 32'h1, "ref output on");
        reg_chk(CTRL_OFFSET, 32'(CTRL_RESET), 32'hffffffff);
        reg_chk(STATUS_OFFSET, 32'h1, 32'h1);
        n0 = rx_edges;
        repeat (100) @(posedge clk);
        check(32'(rx_edges - n0), 32'd20, "ref clock rate");
        apb(1'b1, 8'h0c, 32'hffffffff, rd, err);
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped access");
        reg_chk(CTRL_OFFSET, 32'(CTRL_RESET), 32'hffffffff);
        chk_out = 1'b1;
        frame(8, 1, 1'b0);
        reg_chk(COUNT_OFFSET, 32'd8, 32'hffff);
        set_ctrl(32'h0);
        frame(4, 10, 1'b0);
        set_ctrl(32'h2);
        // the looped-back clock is now the serial bit clock: one bit per clock
        frame(8, 1, 1'b1);
        reg_chk(COUNT_OFFSET, 32'd20, 32'hffff);
        tx_busy = 1'b1;
        mac_u.send_sym(2'h1, 10);
        check(32'(coll), 32'h0, "collision in full duplex");
        mac_u.end_frame();
        set_ctrl(32'h6);
        mac_u.send_sym(2'h1, 20);
        check(32'(coll), 32'h1, "collision pin");
        reg_chk(STATUS_OFFSET, 32'h8, 32'h8);
        mac_u.end_frame();
        tx_busy = 1'b0;
        repeat (40) @(posedge clk);
        check(32'(coll), 32'h0, "collision cleared");
        set_ctrl(32'h9);
        check(32'(rx_oe), 32'h1, "ref output kept in clock mode");
        do_reset(1'b0);
        check(32'(core_clk), 32'h1, "core clock source");
        reg_chk(STATUS_OFFSET, 32'h0, 32'h7);
        check(32'({crs_dv, rx_data}), 32'h0, "idle before ref");
        ref_run = 1'b1;
        repeat (80) @(posedge clk);
        reg_chk(STATUS_OFFSET, 32'h6, 32'h7);
        check(32'(rx_oe), 32'h1, "ref output on");
        chk_out = 1'b1;
        frame(6, 1, 1'b0);
        reg_chk(COUNT_OFFSET, 32'd6, 32'hffff);
        set_ctrl(32'h9);
        check(32'(rx_oe), 32'h0, "ref output off");
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : test_sw_port_iface
